// ==== hdl/move_shift_defines.vh ====
// Constants for the move, shift and indirect execution datapath
`ifndef MOVE_SHIFT_DEFINES_VH
`define MOVE_SHIFT_DEFINES_VH

// APB byte offsets
`define OFS_INSTR 8'h00
`define OFS_ACC 8'h04
`define OFS_STATUS 8'h08
`define OFS_BANK 8'h0c
`define OFS_LATCH 8'h10
`define OFS_PTR0 8'h14
`define OFS_PTR1 8'h18

// Status register bit positions
`define ST_CARRY 0
`define ST_ZERO 1
`define ST_BUSY 8

// Reset values
`define RST_ACC 8'h00
`define RST_BANK 5'h00
`define RST_LATCH 7'h00
`define RST_PTR 16'h0000
`define RST_INSTR 14'h0000

// Instruction word fields (14 bits)
`define OP_HI 13
`define OP_LO 11
`define DEST_BIT 7
`define OFFSET_FORM_BIT 8
`define PTR_SEL_BIT 7

// Operation codes in bits 13:11
`define OP_NOP 3'h0
`define OP_SHIFT 3'h1
`define OP_MOVE 3'h2
`define OP_INDIRECT 3'h3
`define OP_BANK 3'h4
`define OP_LATCH 3'h5
`define OP_ACC 3'h6

// Pointer-update field codes
`define MM_PRE_INC 2'h0
`define MM_PRE_DEC 2'h1
`define MM_POST_INC 2'h2
`define MM_POST_DEC 2'h3

// File addresses that stand for the indirect data port of pointer 0 and 1
`define IND_PORT0 7'h00
`define IND_PORT1 7'h01

`endif

// ==== hdl/move_shift_indirect_ops.v ====
// Execution datapath for shift, moves, indirect reads and literal loads
//
// Notes on behaviour
// - Shift right: zero in, bit 0 to carry
// - Destination bit picks accumulator or file register
// - Move file register, set zero, one pass
// - Indirect read into accumulator via selected pointer
// - Two-bit field picks pre/post increment/decrement
// - Offset form adds signed offset, pointer kept
// - Indirect port redirects to pointer's address
// - Pointers are 16 bits and wrap
// - Bank load takes 5-bit literal, no flags
// - Latch load takes 7-bit literal, no flags
// - Accumulator literal load, no flags, one pass
// - Unused literal-load bits are ignored
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "move_shift_defines.vh"

module move_shift_indirect_ops #(
  parameter PTR_W = 16
) (
  // Clock and reset
  input wire core_clk_i,
  input wire sys_rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Data memory port
  output reg [PTR_W-1:0] mem_addr_o,
  output reg mem_rd_o,
  input wire [7:0] mem_rdata_i,
  output reg mem_we_o,
  output reg [7:0] mem_wdata_o,
  // Status
  output wire busy_o
);

  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_FETCH = 4'b0010;
  localparam [3:0] S_EXEC = 4'b0100;
  localparam [3:0] S_WRITE = 4'b1000;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [13:0] instr_reg;
  reg [7:0] acc_reg;
  reg carry_reg;
  reg zero_reg;
  reg [4:0] bank_selector_reg;
  reg [6:0] program_counter_upper_latch_reg;
  reg [PTR_W-1:0] ptr0_reg;
  reg [PTR_W-1:0] ptr1_reg;

  // Decoded fields
  wire [2:0] opcode;
  wire [6:0] file_addr;
  wire dest_file;
  wire ptr_sel;
  wire offset_form;
  wire [1:0] pointer_update_field;
  wire [5:0] offset_k;

  assign opcode = instr_reg[`OP_HI:`OP_LO];
  assign file_addr = instr_reg[6:0];
  assign dest_file = instr_reg[`DEST_BIT];
  assign ptr_sel = instr_reg[`PTR_SEL_BIT];
  assign offset_form = instr_reg[`OFFSET_FORM_BIT];
  assign pointer_update_field = instr_reg[1:0];
  assign offset_k = instr_reg[5:0];

  // APB decode
  wire apb_access;
  wire apb_wr;
  reg addr_hit;

  assign apb_access = psel_i & penable_i;
  assign apb_wr = apb_access & pwrite_i & state_reg[0];
  assign pready_o = 1'b1;
  assign pslverr_o = apb_access & ~addr_hit;
  assign busy_o = ~state_reg[0];

  always @* begin
    case (paddr_i)
      `OFS_INSTR, `OFS_ACC, `OFS_STATUS, `OFS_BANK,
      `OFS_LATCH, `OFS_PTR0, `OFS_PTR1: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Pointer arithmetic for the selected pointer
  wire [PTR_W-1:0] sel_ptr;
  wire [PTR_W-1:0] eff_addr;
  wire [PTR_W-1:0] next_ptr;

  assign sel_ptr = ptr_sel ? ptr1_reg : ptr0_reg;

  pointer_step #(
    .PTR_W(PTR_W)
  ) u_pointer_step (
    .ptr_i(sel_ptr),
    .offset_form_i(offset_form),
    .pointer_update_field_i(pointer_update_field),
    .offset_i(offset_k),
    .eff_addr_o(eff_addr),
    .next_ptr_o(next_ptr)
  );

  // Data address of a direct file access; the indirect port is not physical
  reg [PTR_W-1:0] file_phys_addr;

  always @* begin
    if (file_addr == `IND_PORT0) begin
      file_phys_addr = ptr0_reg;
    end else if (file_addr == `IND_PORT1) begin
      file_phys_addr = ptr1_reg;
    end else begin
      file_phys_addr = {{(PTR_W-12){1'b0}}, bank_selector_reg, file_addr};
    end
  end

  wire uses_file;
  wire uses_mem;

  assign uses_file = (opcode == `OP_SHIFT) | (opcode == `OP_MOVE);
  assign uses_mem = uses_file | (opcode == `OP_INDIRECT);

  // Result of the data operations
  wire [7:0] shift_result;
  wire [7:0] op_result;

  assign shift_result = {1'b0, mem_rdata_i[7:1]};
  assign op_result = (opcode == `OP_SHIFT) ? shift_result : mem_rdata_i;

  // Sequencer
  always @* begin
    case (state_reg)
      S_IDLE: begin
        state_next = (apb_wr && paddr_i == `OFS_INSTR) ? S_FETCH : S_IDLE;
      end
      S_FETCH: begin
        state_next = S_EXEC;
      end
      S_EXEC: begin
        state_next = S_WRITE;
      end
      S_WRITE: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Instruction register
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      instr_reg <= `RST_INSTR;
    end else if (apb_wr && paddr_i == `OFS_INSTR) begin
      instr_reg <= pwdata_i[13:0];
    end
  end

  // Memory port
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mem_addr_o <= `RST_PTR;
      mem_rd_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_rd_o <= 1'b0;
      mem_we_o <= 1'b0;
      if (state_reg[1]) begin
        mem_rd_o <= uses_mem;
        if (opcode == `OP_INDIRECT) begin
          mem_addr_o <= eff_addr;
        end else begin
          mem_addr_o <= file_phys_addr;
        end
      end
      if (state_reg[2] && uses_file && dest_file) begin
        mem_we_o <= 1'b1;
        mem_wdata_o <= op_result;
      end
    end
  end

  // Pointers: mode update when the address is formed, else APB
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ptr0_reg <= `RST_PTR;
      ptr1_reg <= `RST_PTR;
    end else if (state_reg[1] && opcode == `OP_INDIRECT) begin
      if (ptr_sel) begin
        ptr1_reg <= next_ptr;
      end else begin
        ptr0_reg <= next_ptr;
      end
    end else if (apb_wr && paddr_i == `OFS_PTR0) begin
      ptr0_reg <= pwdata_i[PTR_W-1:0];
    end else if (apb_wr && paddr_i == `OFS_PTR1) begin
      ptr1_reg <= pwdata_i[PTR_W-1:0];
    end
  end

  // Accumulator and flags
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      acc_reg <= `RST_ACC;
      carry_reg <= 1'b0;
      zero_reg <= 1'b0;
    end else if (state_reg[2]) begin
      case (opcode)
        `OP_SHIFT: begin
          carry_reg <= mem_rdata_i[0];
          zero_reg <= (shift_result == 8'h00);
          if (!dest_file) begin
            acc_reg <= shift_result;
          end
        end
        `OP_MOVE: begin
          zero_reg <= (mem_rdata_i == 8'h00);
          if (!dest_file) begin
            acc_reg <= mem_rdata_i;
          end
        end
        `OP_INDIRECT: begin
          acc_reg <= mem_rdata_i;
          zero_reg <= (mem_rdata_i == 8'h00);
        end
        `OP_ACC: begin
          acc_reg <= instr_reg[7:0];
        end
        default: begin
          acc_reg <= acc_reg;
        end
      endcase
    end else if (apb_wr && paddr_i == `OFS_ACC) begin
      acc_reg <= pwdata_i[7:0];
    end else if (apb_wr && paddr_i == `OFS_STATUS) begin
      carry_reg <= pwdata_i[`ST_CARRY];
      zero_reg <= pwdata_i[`ST_ZERO];
    end
  end

  // Bank selector and upper program latch
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      bank_selector_reg <= `RST_BANK;
      program_counter_upper_latch_reg <= `RST_LATCH;
    end else if (state_reg[2] && opcode == `OP_BANK) begin
      bank_selector_reg <= instr_reg[4:0];
    end else if (state_reg[2] && opcode == `OP_LATCH) begin
      program_counter_upper_latch_reg <= instr_reg[6:0];
    end else if (apb_wr && paddr_i == `OFS_BANK) begin
      bank_selector_reg <= pwdata_i[4:0];
    end else if (apb_wr && paddr_i == `OFS_LATCH) begin
      program_counter_upper_latch_reg <= pwdata_i[6:0];
    end
  end

  // Read data
  always @* begin
    case (paddr_i)
      `OFS_INSTR: begin
        prdata_o = {18'h0, instr_reg};
      end
      `OFS_ACC: begin
        prdata_o = {24'h000000, acc_reg};
      end
      `OFS_STATUS: begin
        prdata_o = {23'h0, busy_o, 6'h00, zero_reg, carry_reg};
      end
      `OFS_BANK: begin
        prdata_o = {27'h0, bank_selector_reg};
      end
      `OFS_LATCH: begin
        prdata_o = {25'h0, program_counter_upper_latch_reg};
      end
      `OFS_PTR0: begin
        prdata_o = {{(32-PTR_W){1'b0}}, ptr0_reg};
      end
      `OFS_PTR1: begin
        prdata_o = {{(32-PTR_W){1'b0}}, ptr1_reg};
      end
      default: begin
        prdata_o = 32'h00000000;
      end
    endcase
  end

endmodule // move_shift_indirect_ops
`default_nettype wire

// ==== hdl/pointer_step.v ====
// Effective address and next value of one 16-bit indirect pointer
`timescale 1ns/10ps
`default_nettype none
`include "move_shift_defines.vh"

module pointer_step #(
  parameter PTR_W = 16
) (
  // Pointer and addressing mode
  input wire [PTR_W-1:0] ptr_i,
  input wire offset_form_i,
  input wire [1:0] pointer_update_field_i,
  input wire [5:0] offset_i,
  // Results
  output reg [PTR_W-1:0] eff_addr_o,
  output reg [PTR_W-1:0] next_ptr_o
);

  wire [PTR_W-1:0] inc_w;
  wire [PTR_W-1:0] dec_w;
  wire [PTR_W-1:0] off_w;

  // Modular arithmetic wraps at both ends of the range
  assign inc_w = ptr_i + {{(PTR_W-1){1'b0}}, 1'b1};
  assign dec_w = ptr_i - {{(PTR_W-1){1'b0}}, 1'b1};
  assign off_w = ptr_i + {{(PTR_W-6){offset_i[5]}}, offset_i};

  always @* begin
    eff_addr_o = ptr_i;
    next_ptr_o = ptr_i;
    if (offset_form_i) begin
      eff_addr_o = off_w;
    end else begin
      case (pointer_update_field_i)
        `MM_PRE_INC: begin
          eff_addr_o = inc_w;
          next_ptr_o = inc_w;
        end
        `MM_PRE_DEC: begin
          eff_addr_o = dec_w;
          next_ptr_o = dec_w;
        end
        `MM_POST_INC: begin
          next_ptr_o = inc_w;
        end
        default: begin
          next_ptr_o = dec_w;
        end
      endcase
    end
  end

endmodule // pointer_step
`default_nettype wire

// ==== testbench/move_shift_indirect_ops_props.sv ====
// Port assertions for the move, shift and indirect datapath
`timescale 1ns/10ps
`default_nettype none
`include "move_shift_defines.vh"
module move_shift_indirect_ops_props #(
  parameter PTR_W = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  // Memory and status
  input wire logic [PTR_W-1:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic mem_we_o,
  input wire logic busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic rd = psel_i && penable_i && !pwrite_i;
  wire logic wr = psel_i && penable_i && pwrite_i;
  rd_pulse_a: assert property (mem_rd_o |=> !mem_rd_o) else $error("read strobe too long");
  rd_busy_a: assert property (mem_rd_o |-> busy_o) else $error("read outside a pass");
  we_order_a: assert property (mem_we_o |-> $past(mem_rd_o) && $stable(mem_addr_o)) else $error("bad write");
  start_pass_a: assert property (wr && paddr_i == `OFS_INSTR && !busy_o |=> busy_o) else $error("no start");
  pass_len_a: assert property ($rose(busy_o) |-> busy_o [*3] ##1 !busy_o) else $error("pass length");
  acc_width_a: assert property (rd && paddr_i == `OFS_ACC |-> prdata_o[31:8] == 24'h0) else $error("acc");
  bank_width_a: assert property (rd && paddr_i == `OFS_BANK |-> prdata_o[31:5] == 27'h0) else $error("bank");
  latch_width_a: assert property (rd && paddr_i == `OFS_LATCH |-> prdata_o[31:7] == 25'h0) else $error("latch");
  ptr_width_a: assert property (rd && (paddr_i == `OFS_PTR0 || paddr_i == `OFS_PTR1) |-> prdata_o[31:16] == 16'h0)
    else $error("pointer");
  cover property ($rose(busy_o));
  cover property (mem_we_o);
  cover property (rd && paddr_i == `OFS_PTR0);
endmodule // move_shift_indirect_ops_props
bind move_shift_indirect_ops move_shift_indirect_ops_props #(.PTR_W(PTR_W)) i_props (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o), .busy_o(busy_o));
`default_nettype wire

// ==== testbench/move_shift_indirect_ops_test.sv ====
// Random and corner-case bench for the move, shift and indirect datapath
`timescale 1ns/10ps
`default_nettype none
`include "move_shift_defines.vh"
module move_shift_indirect_ops_test;
  logic core_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i;
  logic [7:0] paddr_i, mem_rdata_i, acc, we_data;
  logic [31:0] pwdata_i;
  wire logic [31:0] prdata_o;
  wire logic pready_o, pslverr_o, mem_rd_o, mem_we_o, busy_o;
  wire logic [15:0] mem_addr_o;
  wire logic [7:0] mem_wdata_o;
  logic c, z;
  logic [4:0] bank;
  logic [6:0] latch;
  logic [15:0] ptr [2];
  logic [15:0] rd_addr;
  logic [15:0] cv [8] = '{16'hffff, 16'h0000, 16'h8000, 16'h8000, 16'h0000, 16'hffff, 16'h1234, 16'h0042};
  logic [13:0] ci [8] = '{14'h1800, 14'h1881, 14'h1920, 14'h199f, 14'h1803, 14'h1882, 14'h0880, 14'h1001};
  int error_cnt, n_compared, n_rd, n_we;
  move_shift_indirect_ops i_move_shift_indirect_ops (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .busy_o(busy_o));
  initial begin
    core_clk_i = 0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // Memory side traffic counters
  always @(posedge core_clk_i) begin
    if (mem_rd_o === 1'b1) begin
      n_rd <= n_rd + 1;
      rd_addr <= mem_addr_o;
    end
    if (mem_we_o === 1'b1) begin
      n_we <= n_we + 1;
      we_data <= mem_wdata_o;
    end
  end
  task chk(string nm, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge core_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task rd(logic [7:0] a, logic [31:0] x, string nm);
    logic [31:0] r;
    logic e;
    apb(0, a, 0, r, e);
    chk(nm, x, r);
  endtask
  task regs;
    rd(`OFS_ACC, {24'h0, acc}, "acc");
    rd(`OFS_STATUS, {30'h0, z, c}, "status");
    rd(`OFS_BANK, {27'h0, bank}, "bank");
    rd(`OFS_LATCH, {25'h0, latch}, "latch");
    rd(`OFS_PTR0, {16'h0, ptr[0]}, "ptr0");
    rd(`OFS_PTR1, {16'h0, ptr[1]}, "ptr1");
  endtask
  task set_ptr(logic [15:0] v, logic s);
    logic [31:0] r;
    logic e;
    ptr[s] = v;
    ptr[!s] = ~v;
    apb(1, `OFS_PTR0, {16'h0, ptr[0]}, r, e);
    apb(1, `OFS_PTR1, {16'h0, ptr[1]}, r, e);
  endtask
  task step(logic [13:0] ins, logic [7:0] m);
    logic [31:0] r;
    logic e, mem, wr;
    logic [15:0] a, p, p1;
    logic [7:0] res;
    int r0, w0;
    mem_rdata_i <= m;
    r0 = n_rd;
    w0 = n_we;
    apb(1, `OFS_INSTR, {18'h0, ins}, r, e);
    repeat (8) begin
      @(posedge core_clk_i);
      #1;
      if (busy_o === 1'b0) break;
    end
    mem = 0;
    res = m;
    a = (ins[6:0] < 7'h02) ? ptr[ins[0]] : {4'h0, bank, ins[6:0]};
    case (ins[13:11])
      `OP_SHIFT: begin
        mem = 1;
        res = {1'b0, m[7:1]};
        c = m[0];
      end
      `OP_MOVE: mem = 1;
      `OP_INDIRECT: begin
        mem = 1;
        p = ptr[ins[7]];
        p1 = ins[0] ? p - 16'h1 : p + 16'h1;
        a = ins[8] ? p + {{10{ins[5]}}, ins[5:0]} : (ins[1] ? p : p1);
        if (!ins[8]) ptr[ins[7]] = p1;
      end
      `OP_BANK: bank = ins[4:0];
      `OP_LATCH: latch = ins[6:0];
      `OP_ACC: acc = ins[7:0];
      default: ;
    endcase
    wr = mem && ins[7] && ins[13:11] != `OP_INDIRECT;
    if (mem) z = (res == 8'h00);
    if (mem && !wr) acc = res;
    chk("reads", {31'h0, mem}, n_rd - r0);
    if (mem) chk("addr", {16'h0, a}, {16'h0, rd_addr});
    chk("writes", {31'h0, wr}, n_we - w0);
    if (wr) chk("wdata", {24'h0, res}, {24'h0, we_data});
    regs;
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #5000000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    logic [31:0] r;
    logic e;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, mem_rdata_i} = '0;
    {acc, c, z, bank, latch, ptr[0], ptr[1]} = '0;
    sys_rst_i = 1;
    void'($urandom(32'hade3efed));
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 0;
    regs;
    apb(0, 8'h1c, 0, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      set_ptr(cv[i], ci[i][7]);
      step(ci[i], i[0] ? 8'h00 : 8'h01);
    end
    $display("test corners done");
    for (int i = 0; i < 64; i++) begin
      if (i % 8 == 0) set_ptr($urandom, 1'($urandom));
      step({3'($urandom), 11'($urandom)}, ($urandom % 4 == 0) ? 8'h00 : 8'($urandom));
    end
    $display("test random done");
    end_of_test;
  end
endmodule // move_shift_indirect_ops_test
`default_nettype wire
